// File: rtl/option_clock_irq_config.sv
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Function
// - readout protection on: program memory contents not returned to reader
// - low-voltage-reset threshold chosen from eight levels by option
// - pwm source option low: selected generators clocked from high rc
// - pwm source option high: selected generators clocked from doubled high rc
// - gating option off: comparator and pwm independent; on: comparator controls
// - gating on and comparator bit 6 high forces all pwm pins low
// - irq bit 0 from port a bit 0 or port b bit 5
// - irq bit 1 from port b bit 0 or port a bit 4
// - port a bit 5 output is open drain only
// - clock mode bit 0 plus pa5 input makes pa5 the reset input
// - crystal control bits 6:5 select low, middle or high range
// - crystal control bit 7 enables the crystal oscillator
// - irq enable and request registers have no reset value
// - global disable blocks every request from reaching the core
// - return from interrupt restores the global enable state
// - value 0x36 selects high rc divided by two, low rc running
// - value 0xA6 selects crystal, low rc running
// - clearing bit 2 disables low rc oscillator
// - value 0x50 disables the running source and hangs the device
// - no crystal status check on switch; early switch hangs device
// - watchdog stops whenever low rc oscillator is disabled
module option_clock_irq_config
	import option_clock_irq_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [7:0] otp_option_word,
	input wire logic prog_read_req,
	input wire logic [15:0] prog_read_word,
	output logic [15:0] prog_read_data,
	output logic prog_read_refused,
	output logic [2:0] low_voltage_reset_level,
	input wire logic porta0_in,
	input wire logic porta4_in,
	input wire logic portb0_in,
	input wire logic portb5_in,
	input wire logic porta5_in,
	output logic porta5_out,
	output logic porta5_oe,
	output logic external_reset_input_n,
	input wire logic engint_pulse,
	input wire logic disgint_pulse,
	input wire logic isr_enter_pulse,
	input wire logic reti_pulse,
	output logic irq_to_core,
	output logic [7:0] porta_digital_input_enable,
	output logic [7:0] portb_digital_input_enable,
	input wire logic [7:0] general_comparator_result,
	input wire logic [PWM_CHANNELS-1:0] pwm_raw,
	output logic [PWM_CHANNELS-1:0] pwm_pin,
	output logic [2:0] pwm_gen_clk_from_high_rc,
	output logic [2:0] pwm_gen_clk_doubled,
	input wire logic crystal_stable,
	output logic crystal_enable,
	output logic [1:0] crystal_range,
	output logic low_rc_enable,
	output sysclk_src_t sysclk_src,
	output logic cpu_hang,
	output logic watchdog_run
);

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic [4:0] pin_meta_q;
	logic [4:0] pin_sync_q;
	logic [4:0] pin_prev_q;
	logic pa0_s, pa4_s, pb0_s, pb5_s, pa5_s;

	// two stages plus an edge stage; the second stage and the edge stage are looked at
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_meta_q <= 5'h1F;
			pin_sync_q <= 5'h1F;
			pin_prev_q <= 5'h1F;
		end else begin
			pin_meta_q <= {porta5_in, portb5_in, portb0_in, porta4_in, porta0_in};
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	assign pa0_s = pin_sync_q[0];
	assign pa4_s = pin_sync_q[1];
	assign pb0_s = pin_sync_q[2];
	assign pb5_s = pin_sync_q[3];
	assign pa5_s = pin_sync_q[4];

	// ****************************************************************
	// code options
	// ****************************************************************
	logic [7:0] option_q;
	logic option_loaded_q;

	// captured on the first edge after reset release, then frozen
	// load once
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			option_q <= BYTE_RESET;
			option_loaded_q <= 1'b0;
		end else if (!option_loaded_q) begin
			option_q <= otp_option_word;
			option_loaded_q <= 1'b1;
		end
	end

	assign low_voltage_reset_level = option_q[OPT_LVR_LO +: 3];

	// readout path: protected parts never show program words
	// readout refusal
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prog_read_data <= 16'h0000;
			prog_read_refused <= 1'b0;
		end else if (prog_read_req) begin
			prog_read_data <= option_q[OPT_SECURITY] ? 16'h0000 : prog_read_word;
			prog_read_refused <= option_q[OPT_SECURITY];
		end
	end

	// ****************************************************************
	// AHB-Lite slave
	// ****************************************************************
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic addr_ok;
	logic [7:0] wdata;
	logic [7:0] clock_mode_q;
	logic [7:0] crystal_ctrl_q;
	logic [1:0] irq_enable_q;
	logic [1:0] irq_request_q;
	logic [7:0] porta_die_q;
	logic [7:0] portb_die_q;
	logic [1:0] pa5_ctrl_q;
	logic [2:0] pwm_sel_q;
	logic gie_q;
	logic gie_saved_q;
	logic hang_q;
	logic [7:0] rd_byte;

	// zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_ok = hsel && hready && htrans[1];
	assign wdata = hwdata[7:0];

	// remember a write address phase for the following data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= BYTE_RESET;
		end else begin
			wr_pend_q <= addr_ok && hwrite;
			wr_addr_q <= haddr[7:0];
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rd_byte = BYTE_RESET;
		if (haddr[7:0] == ADDR_OPTION) begin
			rd_byte = option_q;
		end else if (haddr[7:0] == ADDR_CLOCK_MODE) begin
			rd_byte = clock_mode_q;
		end else if (haddr[7:0] == ADDR_CRYSTAL_CTRL) begin
			rd_byte = crystal_ctrl_q;
		end else if (haddr[7:0] == ADDR_IRQ_ENABLE) begin
			rd_byte = {6'h00, irq_enable_q};
		end else if (haddr[7:0] == ADDR_IRQ_REQUEST) begin
			rd_byte = {6'h00, irq_request_q};
		end else if (haddr[7:0] == ADDR_PORTA_DIE) begin
			rd_byte = porta_die_q;
		end else if (haddr[7:0] == ADDR_PORTB_DIE) begin
			rd_byte = portb_die_q;
		end else if (haddr[7:0] == ADDR_PA5_CTRL) begin
			rd_byte = {6'h00, pa5_ctrl_q};
		end else if (haddr[7:0] == ADDR_PWM_CLK_SEL) begin
			rd_byte = {5'h00, pwm_sel_q};
		end else if (haddr[7:0] == ADDR_STATUS) begin
			rd_byte = {3'h0, crystal_stable, watchdog_run, hang_q, irq_to_core, gie_q};
		end
	end

	// read data registered at the address phase, stands in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_ok && !hwrite) begin
			hrdata <= {24'h00_0000, rd_byte};
		end
	end

	// ****************************************************************
	// clock control
	// ****************************************************************
	// plain control registers written by software
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clock_mode_q <= CLOCK_MODE_REG_RESET;
			crystal_ctrl_q <= BYTE_RESET;
			porta_die_q <= BYTE_RESET;
			portb_die_q <= BYTE_RESET;
			pa5_ctrl_q <= 2'h0;
			pwm_sel_q <= 3'h0;
		end else if (wr_pend_q) begin
			if (wr_addr_q == ADDR_CLOCK_MODE) begin
				clock_mode_q <= wdata;
			end else if (wr_addr_q == ADDR_CRYSTAL_CTRL) begin
				crystal_ctrl_q <= wdata;
			end else if (wr_addr_q == ADDR_PORTA_DIE) begin
				porta_die_q <= wdata;
			end else if (wr_addr_q == ADDR_PORTB_DIE) begin
				portb_die_q <= wdata;
			end else if (wr_addr_q == ADDR_PA5_CTRL) begin
				pa5_ctrl_q <= wdata[1:0];
			end else if (wr_addr_q == ADDR_PWM_CLK_SEL) begin
				pwm_sel_q <= wdata[2:0];
			end
		end
	end

	assign crystal_range = crystal_ctrl_q[XTAL_RANGE_LO +: 2];
	assign crystal_enable = crystal_ctrl_q[XTAL_ENABLE];
	assign low_rc_enable = clock_mode_q[CLOCK_MODE_REG_LOW_RC_EN];
	assign watchdog_run = low_rc_enable && !hang_q;

	// source decode from the select field
	always_comb begin
		case (clock_mode_q[CLOCK_MODE_REG_SEL_LO +: 3])
			SEL_HIGH_RC_DIV2: sysclk_src = SRC_HIGH_RC_DIV2;
			SEL_HIGH_RC: sysclk_src = SRC_HIGH_RC;
			SEL_CRYSTAL: sysclk_src = SRC_CRYSTAL;
			default: sysclk_src = SRC_LOW_RC;
		endcase
	end

	// a dead source stops the core; nothing but reset recovers it,
	// which mirrors silicon where the core loses its clock outright
	// hang detection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hang_q <= 1'b0;
		end else if ((sysclk_src == SRC_LOW_RC && !low_rc_enable) ||
			(sysclk_src == SRC_HIGH_RC && !low_rc_enable &&
			clock_mode_q == CLOCK_MODE_REG_FORBIDDEN) ||
			(sysclk_src == SRC_CRYSTAL && !(crystal_enable && crystal_stable))) begin
			hang_q <= 1'b1;
		end
	end

	assign cpu_hang = hang_q;

	// ****************************************************************
	// port a bit 5 and wakeup enables
	// ****************************************************************
	// open drain: drive only low
	assign porta5_out = 1'b0;
	assign porta5_oe = pa5_ctrl_q[0] && !pa5_ctrl_q[1];
	assign external_reset_input_n = !(clock_mode_q[CLOCK_MODE_REG_PA5_RESET] &&
		!pa5_ctrl_q[0] && !pa5_s);
	assign porta_digital_input_enable = porta_die_q;
	assign portb_digital_input_enable = portb_die_q;

	// ****************************************************************
	// interrupts
	// ****************************************************************
	logic [1:0] src_now;
	logic [1:0] src_prev;
	logic [1:0] src_rise;

	assign src_now[0] = option_q[OPT_IRQ_SRC0] ? pb5_s : pa0_s;
	assign src_prev[0] = option_q[OPT_IRQ_SRC0] ? pin_prev_q[3] : pin_prev_q[0];
	assign src_now[1] = option_q[OPT_IRQ_SRC1] ? pa4_s : pb0_s;
	assign src_prev[1] = option_q[OPT_IRQ_SRC1] ? pin_prev_q[1] : pin_prev_q[2];
	assign src_rise = src_now & ~src_prev;

	// no reset on purpose: contents stay undefined until written
	// no reset value
	always_ff @(posedge hclk) begin
		if (wr_pend_q && wr_addr_q == ADDR_IRQ_ENABLE) begin
			irq_enable_q <= wdata[1:0];
		end
	end

	// an edge in the clearing cycle still sets its bit
	always_ff @(posedge hclk) begin
		if (wr_pend_q && wr_addr_q == ADDR_IRQ_REQUEST) begin
			irq_request_q <= wdata[1:0] | src_rise;
		end else begin
			irq_request_q <= irq_request_q | src_rise;
		end
	end

	// global enable with save on entry and restore on return
	// global enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gie_q <= 1'b0;
			gie_saved_q <= 1'b0;
		end else if (isr_enter_pulse) begin
			gie_saved_q <= gie_q;
			gie_q <= 1'b0;
		end else if (reti_pulse) begin
			gie_q <= gie_saved_q;
		end else if (disgint_pulse) begin
			gie_q <= 1'b0;
		end else if (engint_pulse) begin
			gie_q <= 1'b1;
		end
	end

	assign irq_to_core = gie_q && |(irq_enable_q & irq_request_q);

	// ****************************************************************
	// pwm clocking and comparator gating
	// ****************************************************************
	// generator clock source
	assign pwm_gen_clk_from_high_rc = pwm_sel_q & {3{!option_q[OPT_PWM_SRC]}};
	assign pwm_gen_clk_doubled = pwm_sel_q & {3{option_q[OPT_PWM_SRC]}};

	logic gate_active;
	assign gate_active = option_q[OPT_GATING] && general_comparator_result[CMP_GATE_BIT];

	// registered so pins change on clock edges only
	genvar ch;
	generate
		for (ch = 0; ch < PWM_CHANNELS; ch++) begin : g_pwm
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pwm_pin[ch] <= 1'b0;
				end else begin
					pwm_pin[ch] <= gate_active ? 1'b0 : pwm_raw[ch];
				end
			end
		end
	endgenerate

endmodule

// File: rtl/option_clock_irq_pkg.sv
package option_clock_irq_pkg;

	// ****************************************************************
	// register byte addresses on the AHB-Lite port
	// ****************************************************************
	localparam logic [7:0] ADDR_OPTION = 8'h00;
	localparam logic [7:0] ADDR_CLOCK_MODE = 8'h04;
	localparam logic [7:0] ADDR_CRYSTAL_CTRL = 8'h08;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_REQUEST = 8'h10;
	localparam logic [7:0] ADDR_PORTA_DIE = 8'h14;
	localparam logic [7:0] ADDR_PORTB_DIE = 8'h18;
	localparam logic [7:0] ADDR_PA5_CTRL = 8'h1C;
	localparam logic [7:0] ADDR_PWM_CLK_SEL = 8'h20;
	localparam logic [7:0] ADDR_STATUS = 8'h24;

	// ****************************************************************
	// code option word fields
	// ****************************************************************
	localparam int OPT_SECURITY = 0;
	localparam int OPT_LVR_LO = 1;
	localparam int OPT_PWM_SRC = 4;
	localparam int OPT_GATING = 5;
	localparam int OPT_IRQ_SRC0 = 6;
	localparam int OPT_IRQ_SRC1 = 7;

	// low-voltage-reset level codes
	localparam logic [2:0] LVR_4V00 = 3'h0;
	localparam logic [2:0] LVR_3V50 = 3'h1;
	localparam logic [2:0] LVR_3V00 = 3'h2;
	localparam logic [2:0] LVR_2V75 = 3'h3;
	localparam logic [2:0] LVR_2V50 = 3'h4;
	localparam logic [2:0] LVR_2V20 = 3'h5;
	localparam logic [2:0] LVR_2V00 = 3'h6;
	localparam logic [2:0] LVR_1V80 = 3'h7;

	// ****************************************************************
	// clock mode register fields and documented values
	// ****************************************************************
	localparam int CLOCK_MODE_REG_PA5_RESET = 0;
	localparam int CLOCK_MODE_REG_LOW_RC_EN = 2;
	localparam int CLOCK_MODE_REG_SEL_LO = 5;
	localparam logic [2:0] SEL_HIGH_RC_DIV2 = 3'h1;
	localparam logic [2:0] SEL_HIGH_RC = 3'h2;
	localparam logic [2:0] SEL_CRYSTAL = 3'h5;
	localparam logic [7:0] CLOCK_MODE_REG_TO_HIGH_RC_DIV2 = 8'h36;
	localparam logic [7:0] CLOCK_MODE_REG_TO_CRYSTAL = 8'hA6;
	localparam logic [7:0] CLOCK_MODE_REG_FORBIDDEN = 8'h50;
	localparam logic [7:0] CLOCK_MODE_REG_RESET = 8'h04;

	// crystal control fields
	localparam int XTAL_RANGE_LO = 5;
	localparam int XTAL_ENABLE = 7;
	localparam logic [1:0] XTAL_LOW = 2'h1;
	localparam logic [1:0] XTAL_MID = 2'h2;
	localparam logic [1:0] XTAL_HIGH = 2'h3;

	// comparator result bit that gates PWM pins
	localparam int CMP_GATE_BIT = 6;
	localparam int PWM_CHANNELS = 5;

	// reset values
	localparam logic [7:0] BYTE_RESET = 8'h00;

	typedef enum logic [1:0] {
		SRC_LOW_RC,
		SRC_HIGH_RC_DIV2,
		SRC_HIGH_RC,
		SRC_CRYSTAL
	} sysclk_src_t;

endpackage

// File: verification/option_clock_irq_chk.sv
`timescale 1ns/1ps
module option_clock_irq_chk
	import option_clock_irq_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [7:0] otp_option_word,
	input wire logic prog_read_req,
	input wire logic [15:0] prog_read_word,
	input wire logic [15:0] prog_read_data,
	input wire logic prog_read_refused,
	input wire logic [2:0] low_voltage_reset_level,
	input wire logic porta5_out,
	input wire logic disgint_pulse,
	input wire logic isr_enter_pulse,
	input wire logic reti_pulse,
	input wire logic irq_to_core,
	input wire logic [7:0] general_comparator_result,
	input wire logic [PWM_CHANNELS-1:0] pwm_raw,
	input wire logic [PWM_CHANNELS-1:0] pwm_pin,
	input wire logic low_rc_enable,
	input wire sysclk_src_t sysclk_src,
	input wire logic cpu_hang,
	input wire logic watchdog_run
);
	logic cap_q;
	logic [7:0] opt_q;

	// option word as latched on the first edge after reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_q <= 1'b0;
			opt_q <= 8'h00;
		end else if (!cap_q) begin
			cap_q <= 1'b1;
			opt_q <= otp_option_word;
		end
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_readout_refused: assert property (cap_q && opt_q[0] && prog_read_req
		|=> prog_read_refused && prog_read_data == 16'h0000) else $error("readout not refused");
	a_readout_pass: assert property (cap_q && !opt_q[0] && prog_read_req
		|=> !prog_read_refused && prog_read_data == $past(prog_read_word))
		else $error("readout word wrong");
	a_lvr_level: assert property (cap_q |-> low_voltage_reset_level == opt_q[3:1])
		else $error("lvr level differs from option");
	a_pwm_gate: assert property (cap_q |=> pwm_pin == ($past(pwm_raw) &
		{PWM_CHANNELS{!(opt_q[OPT_GATING] && $past(general_comparator_result[6]))}}))
		else $error("pwm pin gating wrong");
	a_pa5_drain: assert property (porta5_out == 1'b0) else $error("pa5 drives high");
	a_gie_block: assert property (isr_enter_pulse || (disgint_pulse && !reti_pulse)
		|=> !irq_to_core) else $error("irq passed while disabled");
	a_crystal_switch: assert property (hsel && hready && htrans[1] && hwrite
		&& haddr[7:0] == ADDR_CLOCK_MODE ##1 hwdata[7:0] == CLOCK_MODE_REG_TO_CRYSTAL
		|=> sysclk_src == SRC_CRYSTAL && low_rc_enable) else $error("crystal switch wrong");
	a_forbidden_hang: assert property (hsel && hready && htrans[1] && hwrite
		&& haddr[7:0] == ADDR_CLOCK_MODE ##1 hwdata[7:0] == CLOCK_MODE_REG_FORBIDDEN
		|-> ##[1:3] cpu_hang) else $error("forbidden write did not hang");
	a_hang_sticky: assert property (cpu_hang |=> cpu_hang) else $error("hang released");
	a_watchdog_run: assert property (watchdog_run == (low_rc_enable && !cpu_hang))
		else $error("watchdog run wrong");
endmodule

bind option_clock_irq_config option_clock_irq_chk option_clock_irq_chk_inst (.hclk, .hresetn,
	.hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .otp_option_word, .prog_read_req,
	.prog_read_word, .prog_read_data, .prog_read_refused, .low_voltage_reset_level, .porta5_out,
	.disgint_pulse, .isr_enter_pulse, .reti_pulse, .irq_to_core, .general_comparator_result,
	.pwm_raw, .pwm_pin, .low_rc_enable, .sysclk_src, .cpu_hang, .watchdog_run);

// File: verification/pa5_pin_model.sv
`timescale 1ns/1ps
module pa5_pin_model (
	input wire logic porta5_out,
	input wire logic porta5_oe,
	input wire logic button_n,
	output logic porta5_in
);
	// wired-and line: pull-up resistor, chip sink and a button to ground
	// pull-up lifts line
	assign porta5_in = !(porta5_oe && !porta5_out) && button_n;
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	import option_clock_irq_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, prog_read_req, prog_read_refused;
	logic porta0_in, porta4_in, portb0_in, portb5_in, porta5_in, porta5_out, porta5_oe, button_n;
	logic external_reset_input_n, engint_pulse, disgint_pulse, isr_enter_pulse, reti_pulse;
	logic irq_to_core, crystal_stable, crystal_enable, low_rc_enable, cpu_hang, watchdog_run;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, crystal_range;
	logic [2:0] hsize, low_voltage_reset_level, pwm_gen_clk_from_high_rc, pwm_gen_clk_doubled;
	logic [7:0] otp_option_word, general_comparator_result;
	logic [7:0] porta_digital_input_enable, portb_digital_input_enable;
	logic [15:0] prog_read_word, prog_read_data;
	logic [PWM_CHANNELS-1:0] pwm_raw, pwm_pin;
	sysclk_src_t sysclk_src;
	int fail_count, compares;

	option_clock_irq_config option_clock_irq_config_inst (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.otp_option_word, .prog_read_req, .prog_read_word, .prog_read_data, .prog_read_refused,
		.low_voltage_reset_level, .porta0_in, .porta4_in, .portb0_in, .portb5_in, .porta5_in,
		.porta5_out, .porta5_oe, .external_reset_input_n, .engint_pulse, .disgint_pulse,
		.isr_enter_pulse, .reti_pulse, .irq_to_core, .porta_digital_input_enable,
		.portb_digital_input_enable, .general_comparator_result, .pwm_raw, .pwm_pin,
		.pwm_gen_clk_from_high_rc, .pwm_gen_clk_doubled, .crystal_stable, .crystal_enable,
		.crystal_range, .low_rc_enable, .sysclk_src, .cpu_hang, .watchdog_run);
	pa5_pin_model pa5_pin_model_inst (.porta5_out, .porta5_oe, .button_n, .porta5_in);

	// 4 ns clock
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	// ****************************************
	// bus and check helpers
	// ****************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// bounded wait for hready; running out ends the run as a failure
	task automatic wait_ready;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 100) begin
			@(posedge hclk);
			n++;
		end
		if (n >= 100) begin
			fail_count++;
			final_report();
		end
	endtask

	// hsel stays high; idle cycles are marked by htrans only
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		haddr <= {24'h000000, a};
		hwrite <= wr;
		htrans <= 2'h2;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		chk(what, exp, rd);
		chk("hresp", 32'h0, 32'(hresp));
	endtask

	task automatic do_reset(input logic [7:0] opt);
		hresetn <= 1'b0;
		otp_option_word <= opt;
		tick(10);
		hresetn <= 1'b1;
		tick(2);
	endtask

	// one-cycle core pulse: isr_enter, reti, disgint, engint
	task automatic core(input logic [3:0] p, input logic exp);
		{isr_enter_pulse, reti_pulse, disgint_pulse, engint_pulse} <= p;
		tick(1);
		{isr_enter_pulse, reti_pulse, disgint_pulse, engint_pulse} <= 4'h0;
		tick(2);
		chk("irq_to_core", 32'(exp), 32'(irq_to_core));
	endtask

	task automatic readout(input logic exp_ref, input logic [15:0] exp_data);
		prog_read_req <= 1'b1;
		tick(1);
		prog_read_req <= 1'b0;
		tick(1);
		chk("refused", 32'(exp_ref), 32'(prog_read_refused));
		chk("prog data", 32'(exp_data), 32'(prog_read_data));
	endtask

	task automatic final_report;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{hwrite, htrans, haddr, hwdata, prog_read_req, porta0_in, porta4_in} = '0;
		{portb0_in, portb5_in, crystal_stable, pwm_raw, general_comparator_result} = '0;
		{isr_enter_pulse, reti_pulse, disgint_pulse, engint_pulse} = 4'h0;
		{hresetn, hsel, button_n, hsize, prog_read_word} = {3'b011, 3'h2, 16'hC35A};
		{fail_count, compares, otp_option_word} = '0;
		do_reset(8'h77);
		rd_chk("option", ADDR_OPTION, 32'h77);
		bus(1'b1, ADDR_OPTION, 32'h00);
		otp_option_word <= 8'h00;
		rd_chk("option kept", ADDR_OPTION, 32'h77);
		chk("lvr", 32'(LVR_2V75), 32'(low_voltage_reset_level));
		readout(1'b1, 16'h0000);
		rd_chk("unmapped", 8'h3C, 32'h0);
		for (int r = XTAL_LOW; r <= XTAL_HIGH; r++) begin
			bus(1'b1, ADDR_CRYSTAL_CTRL, 32'h80 | (r << 5));
			tick(1);
			chk("xtal range", r, 32'(crystal_range));
			chk("xtal enable", 32'h1, 32'(crystal_enable));
		end
		bus(1'b1, ADDR_PORTA_DIE, 32'hA5);
		bus(1'b1, ADDR_PORTB_DIE, 32'h5A);
		tick(1);
		chk("porta die", 32'hA5, 32'(porta_digital_input_enable));
		chk("portb die", 32'h5A, 32'(portb_digital_input_enable));
		bus(1'b1, ADDR_PA5_CTRL, 32'h1);
		tick(1);
		chk("pa5 low", 32'h0, 32'(porta5_in));
		bus(1'b1, ADDR_PA5_CTRL, 32'h3);
		tick(1);
		chk("pa5 released", 32'h1, 32'({porta5_oe, porta5_in}));
		bus(1'b1, ADDR_PA5_CTRL, 32'h0);
		bus(1'b1, ADDR_CLOCK_MODE, 32'h05);
		button_n <= 1'b0;
		tick(4);
		chk("ext reset", 32'h0, 32'(external_reset_input_n));
		button_n <= 1'b1;
		bus(1'b1, ADDR_PWM_CLK_SEL, 32'h7);
		tick(1);
		chk("pwm doubled", 32'h7, 32'(pwm_gen_clk_doubled));
		chk("ext reset off", 32'h1, 32'(external_reset_input_n));
		pwm_raw <= 5'h1F;
		tick(2);
		chk("pwm open", 32'h1F, 32'(pwm_pin));
		general_comparator_result <= 8'h40;
		tick(2);
		chk("pwm gated", 32'h0, 32'(pwm_pin));
		general_comparator_result <= 8'hBF;
		tick(2);
		chk("pwm resumed", 32'h1F, 32'(pwm_pin));
		bus(1'b1, ADDR_IRQ_ENABLE, 32'h3);
		bus(1'b1, ADDR_IRQ_REQUEST, 32'h0);
		core(4'h1, 1'b0);
		porta0_in <= 1'b1;
		tick(4);
		chk("irq unselected", 32'h0, 32'(irq_to_core));
		portb5_in <= 1'b1;
		tick(4);
		chk("irq selected", 32'h1, 32'(irq_to_core));
		rd_chk("request", ADDR_IRQ_REQUEST, 32'h1);
		core(4'h2, 1'b0);
		core(4'h1, 1'b1);
		core(4'h8, 1'b0);
		core(4'h4, 1'b1);
		bus(1'b1, ADDR_CLOCK_MODE, 32'(CLOCK_MODE_REG_TO_HIGH_RC_DIV2));
		tick(1);
		chk("sysclk", 32'(SRC_HIGH_RC_DIV2), 32'(sysclk_src));
		chk("low rc on", 32'h1, 32'(low_rc_enable));
		bus(1'b1, ADDR_CLOCK_MODE, 32'h32);
		tick(2);
		chk("low rc off", 32'h0, 32'({low_rc_enable, watchdog_run, cpu_hang}));
		crystal_stable <= 1'b1;
		bus(1'b1, ADDR_CLOCK_MODE, 32'(CLOCK_MODE_REG_TO_CRYSTAL));
		tick(2);
		chk("to crystal", 32'h2, 32'({sysclk_src == SRC_CRYSTAL, cpu_hang}));
		$display("test option set one done");
		{porta0_in, portb5_in, crystal_stable, general_comparator_result} <= '0;
		do_reset(8'h80);
		readout(1'b0, 16'hC35A);
		chk("lvr", 32'(LVR_4V00), 32'(low_voltage_reset_level));
		bus(1'b1, ADDR_PWM_CLK_SEL, 32'h7);
		general_comparator_result <= 8'h40;
		tick(2);
		chk("pwm direct", 32'h38, 32'({pwm_gen_clk_from_high_rc, pwm_gen_clk_doubled}));
		chk("pwm free", 32'h1F, 32'(pwm_pin));
		bus(1'b1, ADDR_IRQ_ENABLE, 32'h3);
		bus(1'b1, ADDR_IRQ_REQUEST, 32'h0);
		portb0_in <= 1'b1;
		tick(4);
		rd_chk("request idle", ADDR_IRQ_REQUEST, 32'h0);
		porta4_in <= 1'b1;
		tick(4);
		rd_chk("request src1", ADDR_IRQ_REQUEST, 32'h2);
		bus(1'b1, ADDR_CLOCK_MODE, 32'(CLOCK_MODE_REG_TO_CRYSTAL));
		tick(2);
		chk("early crystal", 32'h1, 32'(cpu_hang));
		$display("test option set two done");
		do_reset(8'h80);
		bus(1'b1, ADDR_CLOCK_MODE, 32'(CLOCK_MODE_REG_FORBIDDEN));
		tick(2);
		chk("forbidden", 32'h3, 32'({sysclk_src == SRC_HIGH_RC, cpu_hang}));
		$display("test forbidden write done");
		final_report();
	end
endmodule
